// [rtl/port_cfg_pkg.sv]
package port_cfg_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_ANALOG_SELECT   = 8'h00;
    localparam logic [7:0] OFF_DIRECTION       = 8'h04;
    localparam logic [7:0] OFF_OUTPUT_LATCH    = 8'h08;
    localparam logic [7:0] OFF_PIN_LEVEL       = 8'h0C;
    localparam logic [7:0] OFF_CHANGE_ENABLE   = 8'h10;
    localparam logic [7:0] OFF_PULLUP          = 8'h14;
    localparam logic [7:0] OFF_PULLDOWN        = 8'h18;
    localparam logic [7:0] OFF_IRQ_STATUS      = 8'h1C;
    localparam logic [7:0] OFF_IRQ_MASK        = 8'h20;
    localparam logic [7:0] OFF_TIMER1_MAP      = 8'h24;
    localparam logic [7:0] OFF_FAULT_A_MAP     = 8'h28;
    localparam logic [7:0] OFF_UART1_MAP       = 8'h2C;
    localparam logic [7:0] OFF_SPI2_MAP        = 8'h30;
    localparam logic [7:0] OFF_OUT_MAP_176_177 = 8'h34;
    localparam logic [7:0] OFF_OUT_MAP_178_179 = 8'h38;

    // ------------------------------------------------------------
    // reset values and field layout
    // ------------------------------------------------------------
    localparam logic [15:0] ANALOG_SELECT_RST = 16'hFFFF;
    localparam logic [7:0]  PIN_SELECT_RST    = 8'h00;
    localparam logic [5:0]  OUT_FUNC_RST      = 6'h00;
    localparam logic [7:0]  PIN_SELECT_MAX    = 8'hB5;
    localparam int          OUT_FUNC_LO_POS   = 0;
    localparam int          OUT_FUNC_HI_POS   = 8;
    localparam int          OUT_FUNC_W        = 6;
    localparam int          SEL_LO_POS        = 0;
    localparam int          SEL_HI_POS        = 8;
    localparam int          IRQ_CHANGE_BIT    = 0;
    localparam logic [31:0] UNMAPPED_READ     = 32'h0000_0000;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] timer1_clock;
        logic [7:0] fault_a;
        logic [7:0] uart1_receive;
        logic [7:0] uart1_clear_to_send;
        logic [7:0] spi2_clock;
        logic [7:0] spi2_data_in;
    } input_select_s;

    typedef struct packed {
        logic timer1_ext_clock;
        logic compare_fault_a;
        logic uart1_receive;
        logic uart1_clear_to_send;
        logic spi2_clock;
        logic spi2_data_in;
    } periph_inputs_s;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DONE = 2'b10
    } bus_state_e;

endpackage

// [rtl/port_pin_config_remap.sv]
// Local design decisions: the Avalon-MM register port and the register offsets.
module port_pin_config_remap
    import port_cfg_pkg::*;
#(
    parameter int PIN_W     = 16,
    parameter int RP_BASE   = 176,
    parameter int RP_COUNT  = 6
) (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // avalon-mm slave
    input  wire logic [7:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic      [31:0]            avs_readdata,
    output logic                        avs_waitrequest,
    // port pins
    input  wire logic [PIN_W-1:0]       pin_in,
    output logic      [PIN_W-1:0]       pin_out,
    output logic      [PIN_W-1:0]       pin_oe_n,
    output logic      [PIN_W-1:0]       pin_pullup_en,
    output logic      [PIN_W-1:0]       pin_pulldown_en,
    output logic      [PIN_W-1:0]       analog_level,
    // remappable pins
    input  wire logic [RP_COUNT-1:0]    rp_in,
    output logic      [4*OUT_FUNC_W-1:0] out_func_sel,
    // peripheral inputs
    output periph_inputs_s              periph_in,
    // interrupt
    output logic                        irq
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0]      analog_select_r;
    logic [15:0]      direction_control_r;
    logic [15:0]      latch_r;
    logic [15:0]      change_notify_enable_r;
    logic [15:0]      weak_pullup_enable_r;
    logic [15:0]      weak_pulldown_enable_r;
    logic [15:0]      last_level_r;
    logic             irq_status_r;
    logic             irq_mask_r;
    input_select_s    sel_r;
    logic [5:0]       func_r [4];
    bus_state_e       bus_state_r;
    bus_state_e       bus_state_nxt;
    logic [31:0]      rdata_nxt;
    logic             wr_go;
    logic             change_seen;
    logic [15:0]      change_event;
    logic [15:0]      wmask;
    logic [15:0]      wdata16;

    assign wr_go   = avs_write && (bus_state_r == BUS_IDLE);
    assign wdata16 = avs_writedata[15:0];
    assign wmask   = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // ------------------------------------------------------------
    // bus handshake: one wait cycle per access
    // ------------------------------------------------------------
    always_comb begin
        bus_state_nxt = bus_state_r;
        case (bus_state_r)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    bus_state_nxt = BUS_DONE;
                end
            end
            BUS_DONE: begin
                bus_state_nxt = BUS_IDLE;
            end
            default: begin
                bus_state_nxt = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bus_state_r     <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end else begin
            bus_state_r     <= bus_state_nxt;
            avs_waitrequest <= !(bus_state_nxt == BUS_DONE);
        end
    end

    // ------------------------------------------------------------
    // pin configuration registers
    // ------------------------------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old_v);
        return (old_v & ~wmask) | (wdata16 & wmask);
    endfunction

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            analog_select_r <= ANALOG_SELECT_RST;
        end else if (wr_go && avs_address == OFF_ANALOG_SELECT) begin
            analog_select_r <= merge16(analog_select_r);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            direction_control_r <= 16'hFFFF;
        end else if (wr_go && avs_address == OFF_DIRECTION) begin
            direction_control_r <= merge16(direction_control_r);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            latch_r <= 16'h0000;
        end else if (wr_go && avs_address == OFF_OUTPUT_LATCH) begin
            latch_r <= merge16(latch_r);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            change_notify_enable_r <= 16'h0000;
        end else if (wr_go && avs_address == OFF_CHANGE_ENABLE) begin
            change_notify_enable_r <= merge16(change_notify_enable_r);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            weak_pullup_enable_r <= 16'h0000;
        end else if (wr_go && avs_address == OFF_PULLUP) begin
            weak_pullup_enable_r <= merge16(weak_pullup_enable_r);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            weak_pulldown_enable_r <= 16'h0000;
        end else if (wr_go && avs_address == OFF_PULLDOWN) begin
            weak_pulldown_enable_r <= merge16(weak_pulldown_enable_r);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_mask_r <= 1'b0;
        end else if (wr_go && avs_address == OFF_IRQ_MASK && avs_byteenable[0]) begin
            irq_mask_r <= avs_writedata[IRQ_CHANGE_BIT];
        end
    end

    // ------------------------------------------------------------
    // peripheral pin select registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sel_r     <= '0;
            func_r[0] <= OUT_FUNC_RST;
            func_r[1] <= OUT_FUNC_RST;
            func_r[2] <= OUT_FUNC_RST;
            func_r[3] <= OUT_FUNC_RST;
        end else if (wr_go) begin
            if (avs_address == OFF_TIMER1_MAP && avs_byteenable[1]) begin
                sel_r.timer1_clock <= avs_writedata[SEL_HI_POS +: 8];
            end else if (avs_address == OFF_FAULT_A_MAP && avs_byteenable[0]) begin
                sel_r.fault_a <= avs_writedata[SEL_LO_POS +: 8];
            end else if (avs_address == OFF_UART1_MAP) begin
                if (avs_byteenable[0]) sel_r.uart1_receive <= avs_writedata[SEL_LO_POS +: 8];
                if (avs_byteenable[1]) sel_r.uart1_clear_to_send <= avs_writedata[SEL_HI_POS +: 8];
            end else if (avs_address == OFF_SPI2_MAP) begin
                if (avs_byteenable[0]) sel_r.spi2_data_in <= avs_writedata[SEL_LO_POS +: 8];
                if (avs_byteenable[1]) sel_r.spi2_clock <= avs_writedata[SEL_HI_POS +: 8];
            end else if (avs_address == OFF_OUT_MAP_176_177) begin
                if (avs_byteenable[0]) func_r[0] <= avs_writedata[OUT_FUNC_LO_POS +: OUT_FUNC_W];
                if (avs_byteenable[1]) func_r[1] <= avs_writedata[OUT_FUNC_HI_POS +: OUT_FUNC_W];
            end else if (avs_address == OFF_OUT_MAP_178_179) begin
                if (avs_byteenable[0]) func_r[2] <= avs_writedata[OUT_FUNC_LO_POS +: OUT_FUNC_W];
                if (avs_byteenable[1]) func_r[3] <= avs_writedata[OUT_FUNC_HI_POS +: OUT_FUNC_W];
            end
        end
    end

    // ------------------------------------------------------------
    // change detection and interrupt
    // ------------------------------------------------------------
    // sampled here on sys_clk; a sleep-time wake path lives outside
    for (genvar g = 0; g < 16; g++) begin : g_change
        assign change_event[g] = (pin_in[g] ^ last_level_r[g]) & change_notify_enable_r[g];
    end
    assign change_seen = |change_event;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            last_level_r <= 16'h0000;
        end else begin
            last_level_r <= pin_in;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_status_r <= 1'b0;
        end else if (change_seen) begin
            irq_status_r <= 1'b1;
        end else if (wr_go && avs_address == OFF_IRQ_STATUS && avs_byteenable[0]
                     && avs_writedata[IRQ_CHANGE_BIT]) begin
            irq_status_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_status_r & irq_mask_r;
        end
    end

    // ------------------------------------------------------------
    // pin drive and analog path
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_out  <= '0;
            pin_oe_n <= '1;
        end else begin
            // latch drives pin in analog mode too
            pin_out  <= latch_r;
            pin_oe_n <= direction_control_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_pullup_en   <= '0;
            pin_pulldown_en <= '0;
        end else begin
            pin_pullup_en   <= weak_pullup_enable_r;
            pin_pulldown_en <= weak_pulldown_enable_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            analog_level <= '0;
        end else begin
            analog_level <= pin_in & analog_select_r;
        end
    end

    // ------------------------------------------------------------
    // remap routing
    // ------------------------------------------------------------
    localparam int N_ROUTE = $bits(periph_inputs_s);

    logic [7:0]         route_sel [N_ROUTE];
    logic [N_ROUTE-1:0] route_hit;

    // struct order, msb first
    assign route_sel[5] = sel_r.timer1_clock;
    assign route_sel[4] = sel_r.fault_a;
    assign route_sel[3] = sel_r.uart1_receive;
    assign route_sel[2] = sel_r.uart1_clear_to_send;
    assign route_sel[1] = sel_r.spi2_clock;
    assign route_sel[0] = sel_r.spi2_data_in;

    for (genvar g = 0; g < N_ROUTE; g++) begin : g_route
        logic hit;
        always_comb begin
            hit = 1'b0;
            for (int i = 0; i < RP_COUNT; i++) begin
                if (route_sel[g] != PIN_SELECT_RST && route_sel[g] <= PIN_SELECT_MAX
                    && int'(route_sel[g]) == RP_BASE + i) begin
                    hit = rp_in[i];
                end
            end
        end
        assign route_hit[g] = hit;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            periph_in <= '0;
        end else begin
            periph_in <= periph_inputs_s'(route_hit);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_func_sel <= '0;
        end else begin
            out_func_sel <= {func_r[3], func_r[2], func_r[1], func_r[0]};
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        rdata_nxt = UNMAPPED_READ;
        if (avs_address == OFF_ANALOG_SELECT) begin
            rdata_nxt[15:0] = analog_select_r;
        end else if (avs_address == OFF_DIRECTION) begin
            rdata_nxt[15:0] = direction_control_r;
        end else if (avs_address == OFF_OUTPUT_LATCH) begin
            rdata_nxt[15:0] = latch_r;
        end else if (avs_address == OFF_PIN_LEVEL) begin
            rdata_nxt[15:0] = pin_in & ~(analog_select_r & direction_control_r);
        end else if (avs_address == OFF_CHANGE_ENABLE) begin
            rdata_nxt[15:0] = change_notify_enable_r;
        end else if (avs_address == OFF_PULLUP) begin
            rdata_nxt[15:0] = weak_pullup_enable_r;
        end else if (avs_address == OFF_PULLDOWN) begin
            rdata_nxt[15:0] = weak_pulldown_enable_r;
        end else if (avs_address == OFF_IRQ_STATUS) begin
            rdata_nxt[IRQ_CHANGE_BIT] = irq_status_r;
        end else if (avs_address == OFF_IRQ_MASK) begin
            rdata_nxt[IRQ_CHANGE_BIT] = irq_mask_r;
        end else if (avs_address == OFF_TIMER1_MAP) begin
            rdata_nxt[SEL_HI_POS +: 8] = sel_r.timer1_clock;
        end else if (avs_address == OFF_FAULT_A_MAP) begin
            rdata_nxt[SEL_LO_POS +: 8] = sel_r.fault_a;
        end else if (avs_address == OFF_UART1_MAP) begin
            rdata_nxt[15:0] = {sel_r.uart1_clear_to_send, sel_r.uart1_receive};
        end else if (avs_address == OFF_SPI2_MAP) begin
            rdata_nxt[15:0] = {sel_r.spi2_clock, sel_r.spi2_data_in};
        end else if (avs_address == OFF_OUT_MAP_176_177) begin
            rdata_nxt[15:0] = {2'b00, func_r[1], 2'b00, func_r[0]};
        end else if (avs_address == OFF_OUT_MAP_178_179) begin
            rdata_nxt[15:0] = {2'b00, func_r[3], 2'b00, func_r[2]};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            avs_readdata <= '0;
        end else if (avs_read && bus_state_r == BUS_IDLE) begin
            avs_readdata <= rdata_nxt;
        end
    end

endmodule

// [testbench/port_pin_config_remap_props.sv]
module port_pin_config_remap_props
    import port_cfg_pkg::*;
#(
    parameter int PIN_W = 16
) (
    // clock and reset
    input wire logic                    sys_clk,
    input wire logic                    rst,
    // bus
    input wire logic [7:0]              avs_address,
    input wire logic                    avs_read,
    input wire logic                    avs_write,
    input wire logic [31:0]             avs_readdata,
    input wire logic                    avs_waitrequest,
    // pins and maps
    input wire logic [PIN_W-1:0]        pin_in,
    input wire logic [PIN_W-1:0]        pin_out,
    input wire logic [PIN_W-1:0]        pin_pullup_en,
    input wire logic [PIN_W-1:0]        pin_pulldown_en,
    input wire logic [PIN_W-1:0]        analog_level,
    input wire logic [4*OUT_FUNC_W-1:0] out_func_sel,
    input wire periph_inputs_s          periph_in,
    input wire logic                    irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic rd_ans;
    assign rd_ans = avs_read && !avs_waitrequest;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_rst_vals;
        $fell(rst) |-> out_func_sel == '0 && periph_in == '0 && !irq;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("maps not cleared by reset");
    property p_asel;
        $fell(rst) |=> analog_level == $past(pin_in);
    endproperty
    a_asel: assert property (p_asel) else $error("analog select not all ones");
    property p_om;
        rd_ans && (avs_address == OFF_OUT_MAP_176_177 || avs_address == OFF_OUT_MAP_178_179)
            |-> avs_readdata[15:14] == 2'h0 && avs_readdata[7:6] == 2'h0;
    endproperty
    a_om: assert property (p_om) else $error("output map gap bits set");
    property p_fa;
        rd_ans && avs_address == OFF_FAULT_A_MAP |-> avs_readdata[31:8] == 24'h0;
    endproperty
    a_fa: assert property (p_fa) else $error("fault select upper byte set");
    property p_pu;
        $changed(pin_pullup_en) |-> $past(avs_write) && $past(avs_address) == OFF_PULLUP;
    endproperty
    a_pu: assert property (p_pu) else $error("pull-up moved without write");
    property p_pd;
        $changed(pin_pulldown_en) |-> $past(avs_write) && $past(avs_address) == OFF_PULLDOWN;
    endproperty
    a_pd: assert property (p_pd) else $error("pull-down moved without write");
    property p_lat;
        $changed(pin_out) |-> $past(avs_write) && $past(avs_address) == OFF_OUTPUT_LATCH;
    endproperty
    a_lat: assert property (p_lat) else $error("pin drive moved without write");
    property p_ofs;
        $changed(out_func_sel) |-> $past(avs_write)
            && ($past(avs_address) == OFF_OUT_MAP_176_177 || $past(avs_address) == OFF_OUT_MAP_178_179);
    endproperty
    a_ofs: assert property (p_ofs) else $error("output function moved without write");
    property p_irq_fall;
        $fell(irq) |-> $past(avs_write, 2)
            && ($past(avs_address, 2) == OFF_IRQ_STATUS || $past(avs_address, 2) == OFF_IRQ_MASK);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without write");
    c_irq: cover property ($rose(irq));
    c_fa: cover property (rd_ans && avs_address == OFF_FAULT_A_MAP);
    c_map: cover property (periph_in.compare_fault_a);
endmodule

bind port_pin_config_remap port_pin_config_remap_props #(.PIN_W(PIN_W)) u_props (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pin_in(pin_in), .pin_out(pin_out), .pin_pullup_en(pin_pullup_en),
    .pin_pulldown_en(pin_pulldown_en), .analog_level(analog_level),
    .out_func_sel(out_func_sel), .periph_in(periph_in), .irq(irq)
);

// [testbench/pin_partner_model.sv]
module pin_partner_model #(
    parameter int PIN_W = 16
) (
    // clock
    input  wire logic             sys_clk,
    // device side
    input  wire logic [PIN_W-1:0] pin_out,
    input  wire logic [PIN_W-1:0] pin_oe_n,
    input  wire logic [PIN_W-1:0] pull_up,
    input  wire logic [PIN_W-1:0] pull_dn,
    // external circuit
    input  wire logic [PIN_W-1:0] ext_val,
    input  wire logic [PIN_W-1:0] ext_en,
    output logic      [PIN_W-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [PIN_W-1:0] float_r = '0;
    always @(posedge sys_clk) float_r <= ~float_r;
    always_comb begin
        for (int i = 0; i < PIN_W; i++) begin
            if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else if (pull_up[i]) pin_in[i] = 1'b1;
            else if (pull_dn[i]) pin_in[i] = 1'b0;
            else pin_in[i] = float_r[i];
        end
    end
endmodule

// [testbench/tb_port_pin_config_remap.sv]
module tb_port_pin_config_remap
    import port_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, irq;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [15:0] pin_in, pin_out, pin_oe_n, pin_pullup_en, pin_pulldown_en, analog_level, ext_val, ext_en;
    logic [5:0] rp_in;
    logic [23:0] out_func_sel;
    periph_inputs_s periph_in;
    int fails = 0, n_tests = 0, cyc = 0;
    logic [7:0] map_off [6] = '{OFF_TIMER1_MAP, OFF_FAULT_A_MAP, OFF_UART1_MAP, OFF_SPI2_MAP,
                                OFF_OUT_MAP_176_177, OFF_OUT_MAP_178_179};
    always #10 sys_clk = ~sys_clk;
    port_pin_config_remap dut_u (
        .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup_en(pin_pullup_en),
        .pin_pulldown_en(pin_pulldown_en), .analog_level(analog_level), .rp_in(rp_in),
        .out_func_sel(out_func_sel), .periph_in(periph_in), .irq(irq));
    pin_partner_model u_pins (
        .sys_clk(sys_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_up(pin_pullup_en),
        .pull_dn(pin_pulldown_en), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic rd, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_read <= rd;
        avs_write <= !rd;
        avs_writedata <= d;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b1, a, 32'h0000_0000);
        chk(q, exp);
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            conclude();
        end
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        ext_val = 16'hA5C3;
        ext_en = 16'hFFFF;
        rp_in = 6'h26;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rd(OFF_ANALOG_SELECT, 32'h0000_FFFF);
        foreach (map_off[i]) rd(map_off[i], 32'h0000_0000);
        rd(OFF_PIN_LEVEL, 32'h0000_0000);
        chk({16'h0000, analog_level}, 32'h0000_A5C3);
        $display("test reset done");
        wr(OFF_ANALOG_SELECT, 32'h0000_00FF);
        rd(OFF_PIN_LEVEL, 32'h0000_A500);
        chk({16'h0000, analog_level}, 32'h0000_00C3);
        wr(OFF_OUTPUT_LATCH, 32'h0000_000A);
        wr(OFF_DIRECTION, 32'h0000_FFF0);
        rd(OFF_PIN_LEVEL, 32'h0000_A50A);
        chk({16'h0000, analog_level}, 32'h0000_00CA);
        $display("test analog done");
        wr(OFF_PULLUP, 32'h0000_1234);
        wr(OFF_PULLDOWN, 32'h0000_8010);
        @(posedge sys_clk);
        chk({pin_pullup_en, pin_pulldown_en}, 32'h1234_8010);
        ext_en <= 16'hEFFF;
        rd(OFF_PIN_LEVEL, 32'h0000_B50A);
        $display("test pulls done");
        wr(OFF_CHANGE_ENABLE, 32'h0000_0200);
        wr(OFF_IRQ_MASK, 32'h0000_0001);
        wr(OFF_IRQ_STATUS, 32'h0000_0001);
        ext_val[10] <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0000_0000);
        ext_val[9] <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0000_0001);
        rd(OFF_IRQ_STATUS, 32'h0000_0001);
        wr(OFF_IRQ_MASK, 32'h0000_0000);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(OFF_IRQ_MASK, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(OFF_IRQ_STATUS, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0000_0000);
        rd(OFF_IRQ_STATUS, 32'h0000_0000);
        $display("test change done");
        wr(OFF_FAULT_A_MAP, 32'h0000_B2B5);
        rd(OFF_FAULT_A_MAP, 32'h0000_00B5);
        wr(OFF_TIMER1_MAP, 32'h0000_B3B3);
        rd(OFF_TIMER1_MAP, 32'h0000_B300);
        wr(OFF_UART1_MAP, 32'h0000_B1B4);
        wr(OFF_SPI2_MAP, 32'h0000_B0B2);
        @(posedge sys_clk);
        chk({26'h0, periph_in}, 32'h0000_0015);
        rp_in <= 6'h19;
        repeat (2) @(posedge sys_clk);
        chk({26'h0, periph_in}, 32'h0000_002A);
        wr(OFF_TIMER1_MAP, 32'h0000_0000);
        repeat (2) @(posedge sys_clk);
        chk({26'h0, periph_in}, 32'h0000_000A);
        $display("test input map done");
        wr(OFF_OUT_MAP_176_177, 32'h0000_FFFF);
        rd(OFF_OUT_MAP_176_177, 32'h0000_3F3F);
        wr(OFF_OUT_MAP_178_179, 32'h0000_2A15);
        rd(OFF_OUT_MAP_178_179, 32'h0000_2A15);
        chk({8'h00, out_func_sel}, {8'h00, 6'h2A, 6'h15, 6'h3F, 6'h3F});
        wr(8'hFC, 32'h0000_FFFF);
        rd(8'hFC, 32'h0000_0000);
        $display("test output map done");
        conclude();
    end
endmodule
